// ===== rtl/usb_node_cfg_pkg.sv
/*
  Constants for the USB node configuration register bank: register offsets,
  field positions, reset values and the accepted clock-frequency range.
  Assumes one system clock and byte-sized configuration addresses.
*/
package usb_node_cfg_pkg;

  // Configuration address width and printed register offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DEVICE_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_NODE_SETUP = 8'h04;
  localparam logic [7:0] OFS_NODE_IDENTIFIER = 8'h05;
  localparam logic [7:0] OFS_SYSTEM_CLOCK_MHZ = 8'h51;
  localparam logic [7:0] OFS_LINK_CONTROL_STATUS = 8'h80;

  // Identity word field positions
  localparam int ID_CHIP_LSB = 24;
  localparam int ID_REV_LSB = 8;
  localparam int ID_VER_LSB = 0;

  // Node setup fields
  localparam int SETUP_LOCK_BIT = 31;
  localparam int SETUP_HDR_BIT = 0;

  // Node identifier field
  localparam int NODE_ID_W = 16;
  localparam logic [15:0] NODE_ID_RESET = 16'h0000;

  // System clock field, reset value and accepted range in MHz
  localparam int SYSCLK_W = 7;
  localparam logic [6:0] SYSCLK_RESET = 7'h19;
  localparam logic [6:0] SYSCLK_MIN = 7'h05;
  localparam logic [6:0] SYSCLK_MAX = 7'h64;

  // Link control and status bit positions
  localparam int LINK_RX_ERROR_BIT = 27;
  localparam int LINK_CREDIT_ISSUED_BIT = 26;
  localparam int LINK_CREDIT_HELD_BIT = 25;
  localparam int LINK_GREETING_BIT = 24;
  localparam int LINK_RX_RESET_BIT = 23;
  localparam int LINK_SYMBOL_GAP_LSB = 11;
  localparam int LINK_TOKEN_GAP_LSB = 0;
  localparam int GAP_W = 11;
  localparam logic [10:0] GAP_RESET = 11'h000;

endpackage

// ===== rtl/usb_node_link_flags.sv
/*
  Link status flags and command pulses for the node configuration bank.
  Assumes the link reports events as one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps

module usb_node_link_flags (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Commands decoded from register writes
  input wire logic i_greeting_write,
  input wire logic i_rx_reset_write,
  // Events from the link
  input wire logic i_credit_gained,
  input wire logic i_credit_granted,
  input wire logic i_rx_error_event,
  // Flags and command pulses
  output logic o_credit_held,
  output logic o_credit_issued,
  output logic o_rx_error,
  output logic o_greeting_pulse,
  output logic o_rx_reset_pulse
);

  // Local transmit credit; a new credit in the clear cycle wins
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_credit_held <= 1'b0;
    end else if (i_credit_gained) begin
      o_credit_held <= 1'b1; // R09
    end else if (i_greeting_write) begin
      o_credit_held <= 1'b0; // R10
    end
  end

  // Credit granted to the far end; restarted by a greeting
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_credit_issued <= 1'b0;
    end else if (i_credit_granted) begin
      o_credit_issued <= 1'b1; // R08
    end else if (i_greeting_write) begin
      o_credit_issued <= 1'b0;
    end
  end

  // Sticky receive error, cleared by a receiver reset
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_error <= 1'b0;
    end else if (i_rx_error_event) begin
      o_rx_error <= 1'b1; // R07
    end else if (i_rx_reset_write) begin
      o_rx_error <= 1'b0;
    end
  end

  // One-cycle command pulses toward the link
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_greeting_pulse <= 1'b0;
      o_rx_reset_pulse <= 1'b0;
    end else begin
      o_greeting_pulse <= i_greeting_write; // R10
      o_rx_reset_pulse <= i_rx_reset_write; // R11
    end
  end

endmodule

// ===== rtl/usb_node_config_regs.sv
/*
  USB node configuration register bank: identity word, node setup with
  lock and header-size select, node identifier, system clock frequency
  and link control and status.
  Assumes a single-cycle configuration request port on the system clock
  and a link that reports credit and error events as pulses.
*/
`timescale 1ns/1ps

// Notes on behaviour
// (R01) Setting bit 31 of node setup blocks further configuration and link control writes; link event flags still update.
// (R02) Header-size select: zero means three-byte headers, one means one-byte; resets zero.
// (R03) Node identifier holds a writable 16-bit value, resets zero, upper bits reserved.
// (R04) System clock field bits 6:0 holds MHz rounded up, resets to 25.
// (R05) Clock writes outside 5 to 100 are ignored and answered with a nack.
// (R06) Software programs the clock field at start-up and on oscillator change.
// (R07) Link bit 27 reads one after receive overflow or illegal token.
// (R08) Bit 26 shows credit granted to the remote end; resets zero.
// (R09) Bit 25 shows this end holds transmit credit; resets zero.
// (R10) Writing one to bit 24 clears local credit and sends a greeting.
// (R11) Writing one to bit 23 resets the receiver to token start.
// (R12) Bits 21:11 give minimum idle clocks minus one between symbols.
// (R13) Bits 10:0 give minimum idle clocks minus one between tokens.
// (R14) Identity word is read-only: chip id, block revision, block version.
// (R15) Lock holds until device reset; software cannot clear it.
// (R16) Command and reserved bits read zero; reserved writes have no effect.
module usb_node_config_regs #(
  parameter logic [7:0] CHIP_IDENTIFIER = 8'h5A, // Arbitrary value
  parameter logic [7:0] BLOCK_REVISION = 8'h3C, // Arbitrary value
  parameter logic [7:0] BLOCK_VERSION = 8'h71 // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Configuration access
  input wire logic i_cfg_req,
  input wire logic i_cfg_write,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic o_cfg_nack,
  output logic [31:0] o_cfg_rdata,
  // Link events
  input wire logic i_link_credit_gained,
  input wire logic i_link_credit_granted,
  input wire logic i_link_rx_error_event,
  // Configuration toward the node and link
  output logic o_config_locked,
  output logic o_header_size_select,
  output logic [15:0] o_node_identifier_value,
  output logic [6:0] o_system_clock_mhz_field,
  output logic [10:0] o_symbol_gap_cycles,
  output logic [10:0] o_token_gap_cycles,
  output logic o_link_greeting_command,
  output logic o_link_rx_reset_command
);

  logic wr_req;
  logic wr_open;
  logic hit_setup;
  logic hit_ident;
  logic hit_clock;
  logic hit_link;
  logic hit_any;
  logic clock_in_range;
  logic greeting_write;
  logic rx_reset_write;
  logic credit_held;
  logic credit_issued;
  logic rx_error;
  logic [31:0] read_value;
  logic [6:0] clock_wdata;

  // Address decode
  assign hit_setup = (i_cfg_addr == usb_node_cfg_pkg::OFS_NODE_SETUP);
  assign hit_ident = (i_cfg_addr == usb_node_cfg_pkg::OFS_NODE_IDENTIFIER);
  assign hit_clock = (i_cfg_addr == usb_node_cfg_pkg::OFS_SYSTEM_CLOCK_MHZ);
  assign hit_link = (i_cfg_addr == usb_node_cfg_pkg::OFS_LINK_CONTROL_STATUS);
  assign hit_any = hit_setup | hit_ident | hit_clock | hit_link
                   | (i_cfg_addr == usb_node_cfg_pkg::OFS_DEVICE_IDENTITY);

  // Write qualification; a set lock shuts every register write out, link event flags still update
  assign wr_req = i_cfg_req & i_cfg_write;
  assign wr_open = wr_req & ~o_config_locked; // R01 R15

  // Clock range check on the field bits only
  assign clock_wdata = i_cfg_wdata[usb_node_cfg_pkg::SYSCLK_W-1:0];
  assign clock_in_range = (clock_wdata >= usb_node_cfg_pkg::SYSCLK_MIN)
                          && (clock_wdata <= usb_node_cfg_pkg::SYSCLK_MAX); // R05

  // Link command strobes
  assign greeting_write = wr_open & hit_link
                          & i_cfg_wdata[usb_node_cfg_pkg::LINK_GREETING_BIT]; // R10
  assign rx_reset_write = wr_open & hit_link
                          & i_cfg_wdata[usb_node_cfg_pkg::LINK_RX_RESET_BIT]; // R11

  // Lock bit: set only, cleared by reset alone
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_config_locked <= 1'b0;
    end else if (wr_open && hit_setup && i_cfg_wdata[usb_node_cfg_pkg::SETUP_LOCK_BIT]) begin
      o_config_locked <= 1'b1; // R01 R15
    end
  end

  // Header-size select
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_header_size_select <= 1'b0; // R02
    end else if (wr_open && hit_setup) begin
      o_header_size_select <= i_cfg_wdata[usb_node_cfg_pkg::SETUP_HDR_BIT]; // R02
    end
  end

  // Node identifier
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_node_identifier_value <= usb_node_cfg_pkg::NODE_ID_RESET; // R03
    end else if (wr_open && hit_ident) begin
      o_node_identifier_value <= i_cfg_wdata[usb_node_cfg_pkg::NODE_ID_W-1:0]; // R03
    end
  end

  // System clock frequency, out-of-range values keep the old one
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_system_clock_mhz_field <= usb_node_cfg_pkg::SYSCLK_RESET; // R04
    end else if (wr_open && hit_clock && clock_in_range) begin
      o_system_clock_mhz_field <= clock_wdata; // R04 R05
    end
  end

  // Symbol and token gap fields
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_symbol_gap_cycles <= usb_node_cfg_pkg::GAP_RESET;
      o_token_gap_cycles <= usb_node_cfg_pkg::GAP_RESET;
    end else if (wr_open && hit_link) begin
      o_symbol_gap_cycles <= i_cfg_wdata[usb_node_cfg_pkg::LINK_SYMBOL_GAP_LSB
                             +: usb_node_cfg_pkg::GAP_W]; // R12
      o_token_gap_cycles <= i_cfg_wdata[usb_node_cfg_pkg::LINK_TOKEN_GAP_LSB
                            +: usb_node_cfg_pkg::GAP_W]; // R13
    end
  end

  // Link flags and command pulses
  usb_node_link_flags u_link_flags (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_greeting_write(greeting_write),
    .i_rx_reset_write(rx_reset_write),
    .i_credit_gained(i_link_credit_gained),
    .i_credit_granted(i_link_credit_granted),
    .i_rx_error_event(i_link_rx_error_event),
    .o_credit_held(credit_held),
    .o_credit_issued(credit_issued),
    .o_rx_error(rx_error),
    .o_greeting_pulse(o_link_greeting_command),
    .o_rx_reset_pulse(o_link_rx_reset_command)
  );

  // Read multiplexer; command and reserved bits read zero
  always_comb begin
    read_value = 32'h0000_0000; // R16
    unique case (1'b1)
      (i_cfg_addr == usb_node_cfg_pkg::OFS_DEVICE_IDENTITY): begin
        read_value[usb_node_cfg_pkg::ID_CHIP_LSB +: 8] = CHIP_IDENTIFIER; // R14
        read_value[usb_node_cfg_pkg::ID_REV_LSB +: 8] = BLOCK_REVISION; // R14
        read_value[usb_node_cfg_pkg::ID_VER_LSB +: 8] = BLOCK_VERSION; // R14
      end
      hit_setup: begin
        read_value[usb_node_cfg_pkg::SETUP_LOCK_BIT] = o_config_locked;
        read_value[usb_node_cfg_pkg::SETUP_HDR_BIT] = o_header_size_select;
      end
      hit_ident: begin
        read_value[usb_node_cfg_pkg::NODE_ID_W-1:0] = o_node_identifier_value; // R03
      end
      hit_clock: begin
        read_value[usb_node_cfg_pkg::SYSCLK_W-1:0] = o_system_clock_mhz_field;
      end
      hit_link: begin
        read_value[usb_node_cfg_pkg::LINK_RX_ERROR_BIT] = rx_error; // R07
        read_value[usb_node_cfg_pkg::LINK_CREDIT_ISSUED_BIT] = credit_issued; // R08
        read_value[usb_node_cfg_pkg::LINK_CREDIT_HELD_BIT] = credit_held; // R09
        read_value[usb_node_cfg_pkg::LINK_SYMBOL_GAP_LSB +: usb_node_cfg_pkg::GAP_W] =
          o_symbol_gap_cycles;
        read_value[usb_node_cfg_pkg::LINK_TOKEN_GAP_LSB +: usb_node_cfg_pkg::GAP_W] =
          o_token_gap_cycles;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // Answer one cycle after each request
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_ack <= 1'b0;
      o_cfg_nack <= 1'b0;
    end else if (i_cfg_req) begin
      if (!hit_any) begin
        o_cfg_ack <= 1'b0;
        o_cfg_nack <= 1'b1;
      end else if (wr_req && hit_clock && !clock_in_range) begin
        o_cfg_ack <= 1'b0;
        o_cfg_nack <= 1'b1; // R05
      end else begin
        o_cfg_ack <= 1'b1;
        o_cfg_nack <= 1'b0;
      end
    end else begin
      o_cfg_ack <= 1'b0;
      o_cfg_nack <= 1'b0;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata <= 32'h0000_0000;
    end else if (i_cfg_req && !i_cfg_write) begin
      o_cfg_rdata <= read_value;
    end
  end

endmodule

// ===== bench/usb_node_config_regs_monitor.sv
/* Port checker for the node configuration bank.
   Assumes binding to usb_node_config_regs on its one clock. */
`timescale 1ns/1ps
module usb_node_config_regs_monitor (
  // Clock, reset and access
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_cfg_req,
  input wire logic i_cfg_write,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  // Answers and outputs
  input wire logic o_cfg_ack,
  input wire logic o_cfg_nack,
  input wire logic o_config_locked,
  input wire logic o_header_size_select,
  input wire logic [15:0] o_node_identifier_value,
  input wire logic [6:0] o_system_clock_mhz_field,
  input wire logic [10:0] o_symbol_gap_cycles,
  input wire logic [10:0] o_token_gap_cycles,
  input wire logic o_link_greeting_command,
  input wire logic o_link_rx_reset_command
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic wr;
  logic ok;
  logic bad;
  logic link_wr;
  logic [31:0] wd_q;
  // Write decodes
  assign wr = i_cfg_req && i_cfg_write;
  assign ok = wr && !o_config_locked;
  assign bad = i_cfg_wdata[6:0] < 7'h05 || i_cfg_wdata[6:0] > 7'h64;
  assign link_wr = ok && i_cfg_addr == 8'h80;
  // Write data bus from the previous cycle
  always_ff @(posedge i_clock) begin
    wd_q <= i_cfg_wdata;
  end
  property p_lock_keep; o_config_locked |=> o_config_locked; endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock dropped");
  property p_lock_block;
    o_config_locked && wr |=> $stable(o_header_size_select) && $stable(o_symbol_gap_cycles)
      && $stable(o_token_gap_cycles) && $stable(o_node_identifier_value)
      && $stable(o_system_clock_mhz_field);
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("locked write took");
  property p_hdr; ok && i_cfg_addr == 8'h04 |=> o_header_size_select == wd_q[0]; endproperty
  a_hdr: assert property (p_hdr) else $error("header select wrong");
  property p_clk_bad;
    wr && i_cfg_addr == 8'h51 && bad |=> o_cfg_nack && $stable(o_system_clock_mhz_field);
  endproperty
  a_clk_bad: assert property (p_clk_bad) else $error("bad clock taken");
  property p_clk_ok;
    ok && i_cfg_addr == 8'h51 && !bad |=> o_cfg_ack && o_system_clock_mhz_field == wd_q[6:0];
  endproperty
  a_clk_ok: assert property (p_clk_ok) else $error("clock not taken");
  property p_greet;
    1'b1 |=> o_link_greeting_command == $past(link_wr && i_cfg_wdata[24]);
  endproperty
  a_greet: assert property (p_greet) else $error("greeting pulse wrong");
  property p_rxrst;
    1'b1 |=> o_link_rx_reset_command == $past(link_wr && i_cfg_wdata[23]);
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("rx reset pulse wrong");
  property p_gaps;
    link_wr |=> o_symbol_gap_cycles == wd_q[21:11] && o_token_gap_cycles == wd_q[10:0];
  endproperty
  a_gaps: assert property (p_gaps) else $error("gap fields wrong");
  // Main scenarios
  c_greet: cover property (o_link_greeting_command);
  c_locked_wr: cover property (o_config_locked && wr);
  c_bad_clk: cover property (wr && i_cfg_addr == 8'h51 && bad);
endmodule

bind usb_node_config_regs usb_node_config_regs_monitor u_monitor (
  .i_clock(i_clock),
  .i_rst_b(i_rst_b),
  .i_cfg_req(i_cfg_req),
  .i_cfg_write(i_cfg_write),
  .i_cfg_addr(i_cfg_addr),
  .i_cfg_wdata(i_cfg_wdata),
  .o_cfg_ack(o_cfg_ack),
  .o_cfg_nack(o_cfg_nack),
  .o_config_locked(o_config_locked),
  .o_header_size_select(o_header_size_select),
  .o_node_identifier_value(o_node_identifier_value),
  .o_system_clock_mhz_field(o_system_clock_mhz_field),
  .o_symbol_gap_cycles(o_symbol_gap_cycles),
  .o_token_gap_cycles(o_token_gap_cycles),
  .o_link_greeting_command(o_link_greeting_command),
  .o_link_rx_reset_command(o_link_rx_reset_command)
);

// ===== bench/usb_link_remote_model.sv
/* Remote end of the token link.
   Assumes command pulses from the bank; answers a greeting after DELAY. */
`timescale 1ns/1ps
module usb_link_remote_model #(
  parameter int DELAY = 3
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Commands and fault injection
  input wire logic i_greeting,
  input wire logic i_rx_reset,
  input wire logic i_inject_error,
  // Link events
  output logic o_credit_gained,
  output logic o_credit_granted,
  output logic o_rx_error_event
);
  int wait_cnt;
  // Credit exchange after a greeting, error on a bad token
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt <= 0;
      o_credit_gained <= 1'b0;
      o_credit_granted <= 1'b0;
      o_rx_error_event <= 1'b0;
    end else begin
      o_credit_gained <= wait_cnt == 1;
      o_credit_granted <= wait_cnt == 1;
      o_rx_error_event <= i_inject_error && !i_rx_reset;
      if (i_greeting) begin
        wait_cnt <= DELAY;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule

// ===== bench/tb_usb_node_config_regs.sv
/* Self-checking bench for the node configuration bank.
   Assumes the remote link model and the bound port checker. */
`timescale 1ns/1ps
module tb_usb_node_config_regs;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic inject = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic ack, nack, locked, hdr, gain, grant, rxerr, greet, rxrst, bad;
  logic [31:0] rdata;
  logic [31:0] good;
  logic [15:0] nid;
  logic [6:0] mhz;
  logic [10:0] sgap, tgap;
  logic [31:0] vals [7] = '{32'h0000_0004, 32'h0000_0005, 32'h0000_0065, 32'h0000_0064,
                            32'h0000_0000, 32'h0000_0480, 32'h0000_0498};
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // Clock at 25 MHz
  always #20 i_clock = ~i_clock;
  usb_node_config_regs DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_cfg_req(req),
    .i_cfg_write(wr), .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_ack(ack),
    .o_cfg_nack(nack), .o_cfg_rdata(rdata), .i_link_credit_gained(gain),
    .i_link_credit_granted(grant), .i_link_rx_error_event(rxerr), .o_config_locked(locked),
    .o_header_size_select(hdr), .o_node_identifier_value(nid), .o_system_clock_mhz_field(mhz),
    .o_symbol_gap_cycles(sgap), .o_token_gap_cycles(tgap), .o_link_greeting_command(greet),
    .o_link_rx_reset_command(rxrst));
  usb_link_remote_model #(.DELAY(10)) u_remote (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_greeting(greet), .i_rx_reset(rxrst), .i_inject_error(inject),
    .o_credit_gained(gain), .o_credit_granted(grant), .o_rx_error_event(rxerr));
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One access; nk is the expected refusal
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic nk, input logic [31:0] exp);
    @(posedge i_clock);
    #1;
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge i_clock);
    #1;
    req = 1'b0;
    chk({30'h0000_0000, ack, nack}, {30'h0000_0000, ~nk, nk});
    if (!w) chk(rdata, exp);
  endtask
  task automatic do_reset;
    i_rst_b = 1'b0;
    repeat (16) @(posedge i_clock);
    #1;
    i_rst_b = 1'b1;
  endtask
  // Main sequence
  initial begin
    do_reset();
    chk({locked, hdr, mhz}, {2'b00, 7'h19});
    acc(1, 8'h51, 32'h0000_0019, 0, 0);
    acc(0, 8'h00, 0, 0, 32'h5A00_3C71);
    acc(1, 8'h00, 32'hFFFF_FFFF, 0, 0);
    acc(0, 8'h00, 0, 0, 32'h5A00_3C71);
    acc(1, 8'h04, 32'h7FFF_FFFF, 0, 0);
    acc(0, 8'h04, 0, 0, 32'h0000_0001);
    chk(hdr, 1);
    acc(0, 8'h05, 0, 0, 0);
    acc(1, 8'h05, 32'hFFFF_ABCD, 0, 0);
    acc(0, 8'h05, 0, 0, 32'h0000_ABCD);
    chk(nid, 32'h0000_ABCD);
    good = 32'h0000_0019;
    foreach (vals[i]) begin
      bad = vals[i][6:0] < 7'h05 || vals[i][6:0] > 7'h64;
      acc(1, 8'h51, vals[i], bad, 0);
      if (!bad) good = {25'h000_0000, vals[i][6:0]};
      acc(0, 8'h51, 0, 0, good);
    end
    acc(0, 8'h80, 0, 0, 0);
    acc(1, 8'h80, 32'h01C0_0801, 0, 0);
    chk({sgap, tgap}, {11'h001, 11'h001});
    acc(0, 8'h80, 0, 0, 32'h0000_0801);
    repeat (14) @(posedge i_clock);
    acc(0, 8'h80, 0, 0, 32'h0600_0801);
    inject = 1'b1;
    @(posedge i_clock);
    #1;
    inject = 1'b0;
    acc(0, 8'h80, 0, 0, 32'h0E00_0801);
    acc(1, 8'h80, 32'h0080_0801, 0, 0);
    acc(0, 8'h80, 0, 0, 32'h0600_0801);
    acc(1, 8'h80, 32'h0100_0801, 0, 0);
    acc(0, 8'h80, 0, 0, 32'h0000_0801);
    acc(0, 8'h10, 0, 1, 0);
    acc(1, 8'h04, 32'h8000_0000, 0, 0);
    chk(locked, 1);
    acc(1, 8'h05, 0, 0, 0);
    acc(1, 8'h51, 32'h0000_0030, 0, 0);
    acc(1, 8'h80, 32'h0100_0000, 0, 0);
    acc(1, 8'h04, 0, 0, 0);
    acc(0, 8'h04, 0, 0, 32'h8000_0000);
    acc(0, 8'h05, 0, 0, 32'h0000_ABCD);
    acc(0, 8'h51, 0, 0, 32'h0000_0018);
    acc(0, 8'h80, 0, 0, 32'h0600_0801);
    do_reset();
    chk(locked, 0);
    chk({hdr, nid, mhz}, {17'h0_0000, 7'h19});
    acc(1, 8'h05, 32'h0000_1234, 0, 0);
    acc(0, 8'h05, 0, 0, 32'h0000_1234);
    test_done();
  end
endmodule
